// ==== src/ast_edge_capture.sv ====
/*
  Capture flip-flop: takes a selected trigger level on a chosen strobe
  edge and holds it between strobes.
  Assumes the data and strobe are synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none

module ast_edge_capture #(
  parameter logic RESET_VAL = 1'h0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic strobe,
  input wire logic sig,
  output logic q
);
  import ast_pkg::*;

  logic q_d;
  logic q_q;

  // ---------------------------------------------------------------
  // capture
  // ---------------------------------------------------------------
  // next value only moves on the strobe, so the level is taken there
  always_comb begin
    q_d = strobe ? sig : q_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_q <= RESET_VAL;
    end else begin
      q_q <= q_d;
    end
  end

  assign q = q_q;

endmodule
`default_nettype wire

// ==== src/ast_interval_counter.sv ====
/*
  Update interval counter: counts timebase steps and emits one pulse
  every N steps.
  Assumes step is a one-cycle pulse per timebase period and n >= 1.
*/
`timescale 1ns/10ps
`default_nettype none

module ast_interval_counter #(
  parameter int CNT_W = ast_pkg::CNT_W_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic step,
  input wire logic [CNT_W-1:0] n,
  output logic tc
);
  import ast_pkg::*;

  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] cnt_q;
  logic tc_d;
  logic tc_q;

  // ---------------------------------------------------------------
  // down counter
  // ---------------------------------------------------------------
  // without a step the count simply holds, which is how a pause freezes it
  always_comb begin
    cnt_d = cnt_q;
    tc_d = 1'h0;
    if (load) begin
      cnt_d = n - {{(CNT_W-1){1'b0}}, 1'b1};
    end else if (step) begin
      if (cnt_q == '0) begin
        tc_d = 1'h1;
        cnt_d = n - {{(CNT_W-1){1'b0}}, 1'b1};
      end else begin
        cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tc_q <= 1'h0;
    end else begin
      cnt_q <= cnt_d;
      tc_q <= tc_d;
    end
  end

  assign tc = tc_q;

endmodule
`default_nettype wire

// ==== src/ast_pkg.sv ====
/*
  Constants shared by the output sample timing engine: state codes, export
  route codes, default widths and the clock figures.
  Assumes nothing of its surroundings.
*/
package ast_pkg;

  // ---------------------------------------------------------------
  // clock
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;

  // ---------------------------------------------------------------
  // default sizes
  // ---------------------------------------------------------------
  localparam int CNT_W_DEF = 16;
  localparam int NTRIG_DEF = 8;
  localparam int SEL_W_DEF = 3;

  // ---------------------------------------------------------------
  // generation state, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    AST_IDLE  = 3'h1,
    AST_ARMED = 3'h2,
    AST_RUN   = 3'h4
  } ast_state_t;

  // ---------------------------------------------------------------
  // export route codes for the function pin and the trigger bus line
  // ---------------------------------------------------------------
  localparam logic [1:0] ROUTE_NONE  = 2'h0;
  localparam logic [1:0] ROUTE_START = 2'h1;
  localparam logic [1:0] ROUTE_PAUSE = 2'h2;
  localparam logic [1:0] ROUTE_SCLK  = 2'h3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic SCLK_IDLE_LEVEL = 1'h1;  // exported clock is active low
  localparam logic GATE_RESET = 1'h1;       // gate reads enabled after reset

endpackage

// ==== src/ast_top.sv ====
/*
  Output sample timing engine: derives the timebase and its synchronising
  inverse, selects and synchronises start and pause triggers, paces the
  converter with a divided or external sample clock, and exports the
  start trigger, pause trigger and sample clock.
  Assumes all pins and configuration inputs are synchronous to clk and
  that timebase_i and ext_sclk_i toggle no faster than clk / 2.
*/
`timescale 1ns/10ps
`default_nettype none

module ast_top #(
  parameter int CNT_W = ast_pkg::CNT_W_DEF,
  parameter int NTRIG = ast_pkg::NTRIG_DEF,
  parameter int SEL_W = ast_pkg::SEL_W_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic timebase_i,
  input wire logic ext_sclk_i,
  input wire logic use_ext_sclk,
  input wire logic rise_mode,
  input wire logic [CNT_W-1:0] interval_n,
  input wire logic [NTRIG-1:0] trig_i,
  input wire logic start_use_sw,
  input wire logic [SEL_W-1:0] start_sel,
  input wire logic sw_start,
  input wire logic pause_en,
  input wire logic [SEL_W-1:0] pause_sel,
  input wire logic arm,
  input wire logic disarm,
  input wire logic [1:0] func_pin_route,
  input wire logic [1:0] bus_route,
  output logic conv_pulse,
  output logic sample_clk_n,
  output logic running,
  output logic paused,
  output logic sync_timebase,
  output logic func_pin_o,
  output logic func_pin_oe,
  output logic trig_bus_o,
  output logic trig_bus_oe
);
  import ast_pkg::*;

  // ---------------------------------------------------------------
  // selector decode
  // ---------------------------------------------------------------
  // out-of-range selections read as low so nothing spurious fires
  function automatic logic pick(input logic [NTRIG-1:0] v,
                                input logic [SEL_W-1:0] s);
    pick = 1'h0;
    for (int i = 0; i < NTRIG; i++) begin
      if (s == SEL_W'(i)) begin
        pick = v[i];
      end
    end
  endfunction

  ast_state_t st_d, st_q;
  logic tb_q, tb_p_q, ex_q, ex_p_q, sync_q;
  logic tb_rise, tb_fall, ex_rise, sync_stb, step_stb;
  logic sel_start, sel_pause, sw_pend_d, sw_pend_q;
  logic start_cap, start_p_d, start_p_q, start_seen;
  logic gate_cap, halt, ctr_load, ctr_step, ctr_tc;
  logic conv_now, conv_d, conv_q, sclk_n_d, sclk_n_q;
  logic paused_d, paused_q;
  logic func_pin_oe_d, func_pin_oe_q, bus_oe_d, bus_oe_q;
  logic func_pin_d, bus_d;

  // ---------------------------------------------------------------
  // timebase and external clock edges
  // ---------------------------------------------------------------
  // one register stage gives the previous level for edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tb_q <= 1'h0;
      tb_p_q <= 1'h0;
      ex_q <= 1'h0;
      ex_p_q <= 1'h0;
      sync_q <= 1'h1;
    end else begin
      tb_q <= timebase_i;
      tb_p_q <= tb_q;
      ex_q <= ext_sclk_i;
      ex_p_q <= ex_q;
      sync_q <= ~timebase_i;            // same phase as ~tb_q, but a flop
    end
  end

  assign tb_rise = tb_q & ~tb_p_q;
  assign tb_fall = ~tb_q & tb_p_q;
  assign ex_rise = ex_q & ~ex_p_q;

  // ---------------------------------------------------------------
  // strobe selection per clock mode
  // ---------------------------------------------------------------
  // the synchronising timebase rises when the timebase falls; inputs are
  // taken half a period ahead of the counting edge so they are settled
  always_comb begin
    if (use_ext_sclk) begin
      sync_stb = ex_rise;
      step_stb = 1'h0;
    end else if (rise_mode) begin
      sync_stb = tb_fall;
      step_stb = tb_rise;
    end else begin
      sync_stb = tb_rise;
      step_stb = tb_fall;
    end
  end

  // ---------------------------------------------------------------
  // selected triggers
  // ---------------------------------------------------------------
  // a software start is a one-cycle pulse that could fall between
  // strobes, so it is held pending until a strobe consumes it
  always_comb begin
    sw_pend_d = sw_pend_q;
    if (sync_stb) begin
      sw_pend_d = 1'h0;
    end
    if (sw_start && start_use_sw) begin
      sw_pend_d = 1'h1;                 // set beats clear on the same cycle
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sw_pend_q <= 1'h0;
    end else begin
      sw_pend_q <= sw_pend_d;
    end
  end

  assign sel_start = start_use_sw ? (sw_pend_q | sw_start)
                                  : pick(trig_i, start_sel);
  assign sel_pause = pick(trig_i, pause_sel);

  // ---------------------------------------------------------------
  // trigger capture flip-flops
  // ---------------------------------------------------------------
  ast_edge_capture #(
    .RESET_VAL(1'h0)
  ) u_start_cap (
    .clk(clk),
    .rst_n(rst_n),
    .strobe(sync_stb),
    .sig(sel_start),
    .q(start_cap)
  );

  ast_edge_capture #(
    .RESET_VAL(GATE_RESET)
  ) u_pause_cap (
    .clk(clk),
    .rst_n(rst_n),
    .strobe(sync_stb),
    .sig(sel_pause),
    .q(gate_cap)
  );

  // a start is recognised on a low-to-high change of the captured level
  always_comb begin
    start_p_d = start_cap;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_p_q <= 1'h0;
    end else begin
      start_p_q <= start_p_d;
    end
  end

  assign start_seen = start_cap & ~start_p_q;

  // ---------------------------------------------------------------
  // generation state
  // ---------------------------------------------------------------
  // disarm wins over everything so software can always stop the run
  always_comb begin
    st_d = st_q;
    case (st_q)
      AST_IDLE: begin
        if (arm && !disarm) begin
          st_d = AST_ARMED;
        end
      end
      AST_ARMED: begin
        if (disarm) begin
          st_d = AST_IDLE;
        end else if (start_seen) begin
          st_d = AST_RUN;
        end
      end
      AST_RUN: begin
        if (disarm) begin
          st_d = AST_IDLE;
        end
      end
      default: begin
        st_d = AST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= AST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // gate low while gating is on halts generation
  assign halt = pause_en & ~gate_cap;

  // ---------------------------------------------------------------
  // update interval counter
  // ---------------------------------------------------------------
  // loaded on the recognised start so the first interval is a full N
  assign ctr_load = (st_q == AST_ARMED) & start_seen;
  assign ctr_step = (st_q == AST_RUN) & ~halt & step_stb;

  ast_interval_counter #(
    .CNT_W(CNT_W)
  ) u_interval (
    .clk(clk),
    .rst_n(rst_n),
    .load(ctr_load),
    .step(ctr_step),
    .n(interval_n),
    .tc(ctr_tc)
  );

  // ---------------------------------------------------------------
  // conversion pulse and exported sample clock
  // ---------------------------------------------------------------
  // the tc pulse is already masked by run and halt through ctr_step; in
  // external mode the external edge is gated the same way
  always_comb begin
    if (use_ext_sclk) begin
      conv_now = ex_rise & (st_q == AST_RUN) & ~halt;
    end else begin
      conv_now = ctr_tc;
    end
    conv_d = conv_now;
    sclk_n_d = ~conv_now;
    paused_d = (st_q == AST_RUN) & halt;
  end

  // the low pulse lasts one clk cycle; its rising edge lands on the
  // next clk edge, in step with the timebase sampling
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conv_q <= 1'h0;
      sclk_n_q <= SCLK_IDLE_LEVEL;
      paused_q <= 1'h0;
    end else begin
      conv_q <= conv_d;
      sclk_n_q <= sclk_n_d;
      paused_q <= paused_d;
    end
  end

  // ---------------------------------------------------------------
  // export routing
  // ---------------------------------------------------------------
  // triggers leave unregistered so no sampling delay is added; the pause
  // code on the function pin is refused and the pin stays undriven
  always_comb begin
    func_pin_oe_d = (func_pin_route == ROUTE_START) |
                    (func_pin_route == ROUTE_SCLK);
    bus_oe_d = (bus_route != ROUTE_NONE);
    case (func_pin_route)
      ROUTE_START: func_pin_d = sel_start;
      ROUTE_SCLK: func_pin_d = sclk_n_q;
      default: func_pin_d = 1'h0;
    endcase
    case (bus_route)
      ROUTE_START: bus_d = sel_start;
      ROUTE_PAUSE: bus_d = sel_pause;
      ROUTE_SCLK: bus_d = sclk_n_q;
      default: bus_d = 1'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      func_pin_oe_q <= 1'h0;
      bus_oe_q <= 1'h0;
    end else begin
      func_pin_oe_q <= func_pin_oe_d;
      bus_oe_q <= bus_oe_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // all leave a flop except the trigger exports, which must add no delay
  assign sync_timebase = sync_q;
  assign conv_pulse = conv_q;
  assign sample_clk_n = sclk_n_q;
  assign running = st_q[2];
  assign paused = paused_q;
  assign func_pin_o = func_pin_d;
  assign func_pin_oe = func_pin_oe_q;
  assign trig_bus_o = bus_d;
  assign trig_bus_oe = bus_oe_q;

endmodule
`default_nettype wire

// ==== tb/ast_far_model.sv ====
/*
  Far-side sources: free-running timebase, external sample clock and
  trigger line levels.
  Assumes clk is the engine clock; outputs move just after its edge.
*/
`timescale 1ns/10ps
`default_nettype none

module ast_far_model #(
  parameter int HALF = 4
) (
  input wire logic clk,
  input wire logic ext_run,
  input wire logic [7:0] trig_cmd,
  output logic timebase_o,
  output logic ext_sclk_o,
  output logic [7:0] trig_o
);
  int cnt = 0;
  logic tb_q = 1'h0;
  logic ex_q = 1'h0;
  logic [7:0] trig_q = 8'h00;

  // -----
  // sources
  // -----
  // timebase never stops: the synchronising inverse relies on it;
  // the external clock stands low while not enabled
  always @(posedge clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      tb_q <= !tb_q;
      ex_q <= ext_run ? !ex_q : 1'h0;
    end
    trig_q <= trig_cmd;
  end
  // one driver per output: the registers above
  assign timebase_o = tb_q;
  assign ext_sclk_o = ex_q;
  assign trig_o = trig_q;
endmodule
`default_nettype wire

// ==== tb/ast_top_sva.sv ====
/*
  Port checker for the sample timing engine, bound to its top.
  Assumes config ports only change while the engine is idle.
*/
`timescale 1ns/10ps
`default_nettype none

module ast_top_sva
  import ast_pkg::*;
#(
  parameter int NTRIG = 8,
  parameter int SEL_W = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic timebase_i,
  input wire logic use_ext_sclk,
  input wire logic rise_mode,
  input wire logic [NTRIG-1:0] trig_i,
  input wire logic start_use_sw,
  input wire logic [SEL_W-1:0] start_sel,
  input wire logic [SEL_W-1:0] pause_sel,
  input wire logic [1:0] func_pin_route,
  input wire logic [1:0] bus_route,
  input wire logic conv_pulse,
  input wire logic sample_clk_n,
  input wire logic running,
  input wire logic paused,
  input wire logic sync_timebase,
  input wire logic func_pin_o,
  input wire logic func_pin_oe,
  input wire logic trig_bus_o,
  input wire logic trig_bus_oe
);
  // -----
  // checks
  // -----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // exported clock goes low for exactly one cycle
  sequence s_low_one;
    !sample_clk_n ##1 sample_clk_n;
  endsequence
  // count edge two cycles back: the inverse timebase fell
  sequence s_count_edge;
    $past(sync_timebase, 3) && !$past(sync_timebase, 2);
  endsequence

  AST_SYNC_INV: assert property (
    $past(rst_n) && !use_ext_sclk |-> sync_timebase == !$past(timebase_i))
    else $error("sync timebase is not the inverse");
  AST_CONV_EDGE: assert property (
    conv_pulse && rise_mode && !use_ext_sclk |-> s_count_edge)
    else $error("conversion not two cycles after a count edge");
  AST_START_PIN: assert property (
    $past(func_pin_route) == ROUTE_START && func_pin_route == ROUTE_START &&
    !start_use_sw |-> func_pin_o == trig_i[start_sel])
    else $error("start export is not a direct copy");
  AST_PAUSE_BUS: assert property (
    $past(bus_route) == ROUTE_PAUSE && bus_route == ROUTE_PAUSE
    |-> trig_bus_o == trig_i[pause_sel])
    else $error("pause export is not a direct copy");
  AST_SCLK_PIN: assert property (
    $past(func_pin_route) == ROUTE_SCLK && func_pin_route == ROUTE_SCLK
    |-> func_pin_o == sample_clk_n)
    else $error("exported clock differs from sample clock");
  AST_SCLK_PAIR: assert property (
    conv_pulse != sample_clk_n)
    else $error("sample clock low does not match conversion");
  AST_SCLK_LOW: assert property (
    $fell(sample_clk_n) |-> s_low_one)
    else $error("sample clock low not one cycle");
  AST_PIN_OE: assert property (
    $past(rst_n) |-> func_pin_oe == ($past(func_pin_route) inside {1, 3}))
    else $error("pin enable wrong for route");
  AST_BUS_OE: assert property (
    $past(rst_n) |-> trig_bus_oe == ($past(bus_route) != ROUTE_NONE))
    else $error("bus enable wrong for route");
  AST_PAUSE_HOLD: assert property (
    paused && $past(paused) && $past(paused, 2) |-> !conv_pulse)
    else $error("conversion while paused");
  AST_NO_EARLY: assert property (
    !running && !$past(running) && !$past(running, 2) |-> !conv_pulse)
    else $error("conversion without a run");
endmodule

bind ast_top ast_top_sva #(.NTRIG(NTRIG), .SEL_W(SEL_W)) u_ast_top_sva (
  .clk(clk), .rst_n(rst_n), .timebase_i(timebase_i),
  .use_ext_sclk(use_ext_sclk), .rise_mode(rise_mode), .trig_i(trig_i),
  .start_use_sw(start_use_sw), .start_sel(start_sel),
  .pause_sel(pause_sel), .func_pin_route(func_pin_route),
  .bus_route(bus_route), .conv_pulse(conv_pulse),
  .sample_clk_n(sample_clk_n),
  .running(running), .paused(paused), .sync_timebase(sync_timebase),
  .func_pin_o(func_pin_o), .func_pin_oe(func_pin_oe),
  .trig_bus_o(trig_bus_o), .trig_bus_oe(trig_bus_oe));
`default_nettype wire

// ==== tb/tb.sv ====
/*
  Self-checking bench for the sample timing engine.
  Assumes a timebase and external clock period of eight clk cycles.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  import ast_pkg::*;
  logic clk, rst_n, ext_run, use_ext_sclk, rise_mode, start_use_sw;
  logic sw_start, pause_en, arm, disarm, timebase_i, ext_sclk_i;
  logic [15:0] interval_n;
  logic [7:0] trig_cmd, trig_i;
  logic [2:0] start_sel, pause_sel;
  logic [1:0] func_pin_route, bus_route;
  logic conv_pulse, sample_clk_n, running, paused, sync_timebase;
  logic func_pin_o, func_pin_oe, trig_bus_o, trig_bus_oe;
  int n_errors = 0;
  int checked = 0;

  ast_far_model u_ast_far_model (.clk(clk), .ext_run(ext_run),
    .trig_cmd(trig_cmd), .timebase_o(timebase_i),
    .ext_sclk_o(ext_sclk_i), .trig_o(trig_i));
  ast_top u_ast_top (.clk(clk), .rst_n(rst_n), .timebase_i(timebase_i),
    .ext_sclk_i(ext_sclk_i), .use_ext_sclk(use_ext_sclk),
    .rise_mode(rise_mode), .interval_n(interval_n), .trig_i(trig_i),
    .start_use_sw(start_use_sw), .start_sel(start_sel),
    .sw_start(sw_start), .pause_en(pause_en), .pause_sel(pause_sel),
    .arm(arm), .disarm(disarm), .func_pin_route(func_pin_route),
    .bus_route(bus_route), .conv_pulse(conv_pulse),
    .sample_clk_n(sample_clk_n), .running(running), .paused(paused),
    .sync_timebase(sync_timebase), .func_pin_o(func_pin_o),
    .func_pin_oe(func_pin_oe),
    .trig_bus_o(trig_bus_o), .trig_bus_oe(trig_bus_oe));

  // -----
  // helpers
  // -----
  task automatic chk(input logic got, input logic exp, input string m);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic chk_n(input int got, input int exp, input string m);
    checked++;
    if (got != exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %0d", $time, m, got);
    end
  endtask
  // counts edges up to the next conversion, giving up after lim
  task automatic wait_conv(input int lim, output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (conv_pulse !== 1'h1 && k < lim);
  endtask
  // partner takes the level one edge later
  task automatic flip(input int line, input logic v);
    @(posedge clk);
    trig_cmd[line] <= v;
    @(posedge clk);
    #1;
  endtask
  // start line held low long enough to be captured low first
  task automatic start_run(input logic [15:0] n, input logic sw);
    int k;
    @(posedge clk);
    interval_n <= n;
    start_use_sw <= sw;
    trig_cmd[start_sel] <= 1'h0;
    arm <= 1'h1;
    @(posedge clk);
    arm <= 1'h0;
    repeat (20) @(posedge clk);
    if (sw) sw_start <= 1'h1;
    else trig_cmd[start_sel] <= 1'h1;
    @(posedge clk);
    sw_start <= 1'h0;
    k = 0;
    while (running !== 1'h1 && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(running, 1'h1, "start not recognised");
  endtask
  task automatic stop_run;
    @(posedge clk);
    disarm <= 1'h1;
    @(posedge clk);
    disarm <= 1'h0;
    #1;
    chk(running, 1'h0, "still running after disarm");
  endtask

  // -----
  // scenarios
  // -----
  task automatic t_idle;
    @(posedge clk);
    #1;
    chk(sample_clk_n, 1'h1, "sample clock idle level");
    chk(func_pin_oe, 1'h0, "pin driven after reset");
    flip(3, 1'h1);
    repeat (20) @(posedge clk);
    #1;
    chk(running, 1'h0, "start taken while idle");
    flip(3, 1'h0);
  endtask
  task automatic t_export;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      func_pin_route <= 2'(i);
      bus_route <= 2'(i);
      @(posedge clk);
      #1;
      chk(func_pin_oe, i == 1 || i == 3, "pin enable");
      chk(trig_bus_oe, i != 0, "bus enable");
      for (int v = 1; v >= 0; v--) begin
        flip(i == 2 ? 5 : 3, v[0]);
        if (i == 1) chk(func_pin_o, v[0], "start pin copy");
        if (i == 1) chk(trig_bus_o, v[0], "start bus copy");
        if (i == 3) chk(trig_bus_o, 1'h1, "bus clock idle");
        if (i == 2) chk(trig_bus_o, v[0], "pause bus copy");
      end
    end
  endtask
  task automatic t_divided(input logic [15:0] n);
    int k;
    start_run(n, 1'h0);
    wait_conv(200, k);
    chk_n(k, 8 * n - 4, "first conversion");
    wait_conv(200, k);
    chk_n(k, 8 * n, "conversion spacing");
    chk(sample_clk_n, 1'h0, "sample clock not low");
    stop_run;
  endtask
  task automatic t_pause;
    int k;
    @(posedge clk);
    pause_en <= 1'h1;
    trig_cmd[5] <= 1'h1;
    start_run(16'h0002, 1'h1);
    wait_conv(40, k);
    flip(5, 1'h0);
    repeat (10) @(posedge clk);
    #1;
    chk(paused, 1'h1, "gate low did not pause");
    wait_conv(40, k);
    chk(conv_pulse, 1'h0, "conversion while paused");
    flip(5, 1'h1);
    wait_conv(40, k);
    chk(conv_pulse, 1'h1, "no resume after pause");
    chk(paused, 1'h0, "still paused with gate high");
    stop_run;
    pause_en <= 1'h0;
  endtask
  task automatic t_external;
    int k;
    @(posedge clk);
    use_ext_sclk <= 1'h1;
    ext_run <= 1'h1;
    func_pin_route <= ROUTE_SCLK;
    start_run(16'h0001, 1'h0);
    wait_conv(40, k);
    wait_conv(40, k);
    chk_n(k, 8, "external clock spacing");
    chk(func_pin_o, 1'h0, "exported clock not low");
    chk(trig_bus_o, 1'h0, "bus clock not low");
    stop_run;
  endtask

  // -----
  // run
  // -----
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #20 clk = !clk;
  end
  // all scenarios need well under 2000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    tally_and_finish;
  end
  initial begin
    {rst_n, ext_run, use_ext_sclk, start_use_sw, sw_start} = 5'h00;
    {pause_en, arm, disarm, func_pin_route, bus_route} = 7'h00;
    rise_mode = 1'h1;
    interval_n = 16'h0001;
    trig_cmd = 8'h00;
    start_sel = 3'h3;
    pause_sel = 3'h5;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    t_idle;
    t_export;
    t_divided(16'h0001);
    t_divided(16'h0003);
    // falling-edge mode: strobe on timebase rise, count on its fall
    @(posedge clk);
    rise_mode <= 1'h0;
    t_divided(16'h0002);
    @(posedge clk);
    rise_mode <= 1'h1;
    t_pause;
    t_external;
    tally_and_finish;
  end
endmodule
`default_nettype wire
